// ===== rtl/rpm_pkg.sv
// constants shared by the receive performance monitor counter bank
package rpm_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] LINE_VIOLATION_COUNT_HIGH_IDX = 12'h900;
  localparam logic [11:0] LINE_VIOLATION_COUNT_LOW_IDX = 12'h901;
  localparam logic [11:0] FRAME_ALIGN_ERROR_COUNT_HIGH_IDX = 12'h902;
  localparam logic [11:0] FRAME_ALIGN_ERROR_COUNT_LOW_IDX = 12'h903;
  localparam logic [11:0] IRQ_STATUS_IDX = 12'h904;
  localparam logic [11:0] IRQ_MASK_IDX = 12'h905;

  // ----------------------------------------------------------------
  // widths and counter layout
  // ----------------------------------------------------------------
  localparam int COUNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int NUM_COUNTERS = 2;
  localparam int CNT_LINE_VIOLATION = 0;
  localparam int CNT_FRAME_ALIGN = 1;
  localparam int MIN_ADDR_W = 14;

  // ----------------------------------------------------------------
  // interrupt status and mask bit positions
  // ----------------------------------------------------------------
  localparam int NUM_IRQ = 4;
  localparam int IRQ_LINE_VIOLATION_EVENT = 0;
  localparam int IRQ_FRAME_ALIGN_EVENT = 1;
  localparam int IRQ_LINE_VIOLATION_SAT = 2;
  localparam int IRQ_FRAME_ALIGN_SAT = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== rtl/rpm_counter.sv
// one saturating clear-on-read event counter with high-then-low byte snapshot
`timescale 1ns/100ps
`default_nettype none

module rpm_counter #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic event_pulse,
  input wire logic rd_high,
  input wire logic rd_low,
  output logic [WIDTH-1:0] count,
  output logic [7:0] snap_low,
  output logic snap_valid,
  output logic sat_hit
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (WIDTH != 2 * rpm_pkg::BYTE_W) begin : g_bad_width
      $error("rpm_counter serves exactly two bytes");
    end
  endgenerate

  localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] next_count;
  logic [7:0] next_snap_low;
  logic next_snap_valid;
  logic [WIDTH-1:0] fresh;

  // an event lost at saturation is flagged so software can tell the count is a floor
  assign sat_hit = event_pulse && (count == ALL_ONES);

  // next value of the count and the low-byte snapshot
  always_comb begin
    fresh = event_pulse ? ONE : rpm_pkg::COUNT_RESET; // the event in the read cycle survives
    next_count = count;
    next_snap_low = snap_low;
    next_snap_valid = snap_valid;
    if (event_pulse && (count != ALL_ONES)) begin
      next_count = count + ONE; // [R1] [R4] [R9]
    end
    if (rd_high) begin
      // the whole value moves out here, so events after this read start the next interval
      next_snap_low = count[7:0]; // [R9] [R6]
      next_snap_valid = 1'b1;
      next_count = fresh; // [R3] [R7] [R8]
    end else if (rd_low) begin
      next_snap_valid = 1'b0; // [R7]
      if (!snap_valid) begin
        next_count = fresh; // [R3]
      end
    end
  end

  // register the counter state
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count <= rpm_pkg::COUNT_RESET;
      snap_low <= rpm_pkg::BYTE_RESET;
      snap_valid <= 1'b0;
    end else begin
      count <= next_count;
      snap_low <= next_snap_low;
      snap_valid <= next_snap_valid;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/rpm_perf_monitor.sv
// receive performance monitor counter bank with an AXI4-Lite register slave
//
// How it works
// R1: line code violations are counted in sixteen bits since the last read.
// R2: the low byte of the line violation count reads at index 0x901.
// R3: reading a counter register clears the counter so later reads see new events.
// R4: framing alignment errors counted in sixteen bits; high byte reads at index 0x902.
// R5: the low byte of the framing alignment count reads at index 0x903.
// R6: software reads the high byte before the low byte for a coherent value.
// R7: reading high then low byte gives one coherent value; the counter clears at the high read, before the low read.
// R8: the line violation high byte reads at index 0x900 and also clears on read.
// R9: counters step by one, stick at all ones, and high read snapshots the low byte.
`timescale 1ns/100ps
`default_nettype none

module rpm_perf_monitor #(
  parameter int ADDR_W = 14
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic line_violation_pulse,
  input wire logic frame_align_error_pulse,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (ADDR_W < rpm_pkg::MIN_ADDR_W) begin : g_bad_addr
      $error("rpm_perf_monitor needs at least 14 address bits");
    end
  endgenerate

  // the register index is the byte address without its two lane bits
  localparam int IDX_W = ADDR_W - 2;
  localparam int NC = rpm_pkg::NUM_COUNTERS;
  localparam int NI = rpm_pkg::NUM_IRQ;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // per-counter strobes and state, one entry per event source
  logic [NC-1:0] ev_in;
  logic [NC-1:0] rd_high;
  logic [NC-1:0] rd_low;
  logic [NC-1:0] sat_hit;
  logic [NC-1:0] snap_valid;
  logic [rpm_pkg::COUNT_W-1:0] count [NC];
  logic [7:0] snap_low [NC];

  // event strobes come from framer logic on mclk, so no synchroniser is needed
  assign ev_in[rpm_pkg::CNT_LINE_VIOLATION] = line_violation_pulse;
  assign ev_in[rpm_pkg::CNT_FRAME_ALIGN] = frame_align_error_pulse;

  // one counter per event source; all share the same clear-on-read behaviour
  generate
    for (genvar i = 0; i < NC; i++) begin : g_cnt
      rpm_counter #(
        .WIDTH(rpm_pkg::COUNT_W)
      ) u_cnt (
        .mclk(mclk),
        .resetn(resetn),
        .event_pulse(ev_in[i]),
        .rd_high(rd_high[i]),
        .rd_low(rd_low[i]),
        .count(count[i]),
        .snap_low(snap_low[i]),
        .snap_valid(snap_valid[i]),
        .sat_hit(sat_hit[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  // compare the word index of a byte address; the two lane bits never matter
  function automatic logic is_idx(input logic [ADDR_W-1:0] addr, input logic [11:0] idx);
    is_idx = (addr[ADDR_W-1:2] == IDX_W'(idx));
  endfunction

  // ----------------------------------------------------------------
  // write channel, interrupt status and mask
  // ----------------------------------------------------------------
  // held request halves and software-visible interrupt state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic [NI-1:0] irq_status;
  logic [NI-1:0] irq_mask;

  // next values, registered below
  logic next_aw_held;
  logic next_w_held;
  logic [ADDR_W-1:0] next_awaddr_q;
  logic [7:0] next_wbyte_q;
  logic next_wlane_q;
  logic [NI-1:0] next_irq_status;
  logic [NI-1:0] next_irq_mask;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_irq;

  // per-cycle set and clear vectors for the sticky status bits
  logic [NI-1:0] irq_set;
  logic [NI-1:0] irq_clr;
  logic do_write;

  // address and data are taken independently; the write commits once both are held
  always_comb begin
    // everything holds unless a handshake or the commit below changes it
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wbyte_q = wbyte_q;
    next_wlane_q = wlane_q;
    next_irq_mask = irq_mask;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    irq_clr = '0;
    irq_set = '0;
    do_write = aw_held && w_held && !s_axi_bvalid;

    // take the address; it waits in awaddr_q until the data is also held
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    // take the data; only the low byte lane carries register bits
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wbyte_q = s_axi_wdata[7:0];
      next_wlane_q = s_axi_wstrb[0];
    end
    // commit: decode the held address and raise the response
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = rpm_pkg::RESP_OKAY;
      if (is_idx(awaddr_q, rpm_pkg::IRQ_STATUS_IDX)) begin
        if (wlane_q) begin
          irq_clr = wbyte_q[NI-1:0];
        end
      end else if (is_idx(awaddr_q, rpm_pkg::IRQ_MASK_IDX)) begin
        if (wlane_q) begin
          next_irq_mask = wbyte_q[NI-1:0];
        end
      end else if (is_idx(awaddr_q, rpm_pkg::LINE_VIOLATION_COUNT_HIGH_IDX) ||
                   is_idx(awaddr_q, rpm_pkg::LINE_VIOLATION_COUNT_LOW_IDX) ||
                   is_idx(awaddr_q, rpm_pkg::FRAME_ALIGN_ERROR_COUNT_HIGH_IDX) ||
                   is_idx(awaddr_q, rpm_pkg::FRAME_ALIGN_ERROR_COUNT_LOW_IDX)) begin
        next_bresp = rpm_pkg::RESP_OKAY; // counters are read-only; the write is dropped
      end else begin
        next_bresp = rpm_pkg::RESP_SLVERR;
      end
    end
    // response taken: the write path is free again next cycle
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // event sticky bits: set wins over a write-one clear in the same cycle
    irq_set[rpm_pkg::IRQ_LINE_VIOLATION_EVENT] = ev_in[rpm_pkg::CNT_LINE_VIOLATION];
    irq_set[rpm_pkg::IRQ_FRAME_ALIGN_EVENT] = ev_in[rpm_pkg::CNT_FRAME_ALIGN];
    irq_set[rpm_pkg::IRQ_LINE_VIOLATION_SAT] = sat_hit[rpm_pkg::CNT_LINE_VIOLATION];
    irq_set[rpm_pkg::IRQ_FRAME_ALIGN_SAT] = sat_hit[rpm_pkg::CNT_FRAME_ALIGN];
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
    // irq is built from next values so it moves in the same cycle as status and mask
    next_irq = |(next_irq_status & next_irq_mask);
    // readies drop while a word is held or a response waits, so one write at a time
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  // register the write side
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= rpm_pkg::BYTE_RESET;
      wlane_q <= 1'b0;
      irq_status <= rpm_pkg::IRQ_STATUS_RESET;
      irq_mask <= rpm_pkg::IRQ_MASK_RESET;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rpm_pkg::RESP_OKAY;
      irq <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wbyte_q <= next_wbyte_q;
      wlane_q <= next_wlane_q;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // read channel and clear-on-read strobes
  // ----------------------------------------------------------------
  // read-side next values and decode helpers
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic ar_take;
  logic [7:0] rbyte;

  // the read side effect fires in the cycle the address is taken, exactly once per read
  always_comb begin
    // defaults keep a standing answer unchanged until the master takes it
    ar_take = s_axi_arvalid && s_axi_arready;
    rd_high = '0;
    rd_low = '0;
    rbyte = rpm_pkg::BYTE_RESET;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;

    // decode and launch the answer, and the clear side effect, in the take cycle
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rresp = rpm_pkg::RESP_OKAY;
      if (is_idx(s_axi_araddr, rpm_pkg::LINE_VIOLATION_COUNT_HIGH_IDX)) begin
        // the high read hands the low byte to the snapshot and restarts the count
        rbyte = count[rpm_pkg::CNT_LINE_VIOLATION][15:8]; // [R8]
        rd_high[rpm_pkg::CNT_LINE_VIOLATION] = 1'b1; // [R3] [R8]
      end else if (is_idx(s_axi_araddr, rpm_pkg::LINE_VIOLATION_COUNT_LOW_IDX)) begin
        // a lone low read clears the whole count, so software that skips the high
        // read loses the upper byte
        rbyte = snap_valid[rpm_pkg::CNT_LINE_VIOLATION] ?
                snap_low[rpm_pkg::CNT_LINE_VIOLATION] :
                count[rpm_pkg::CNT_LINE_VIOLATION][7:0]; // [R2] [R6]
        rd_low[rpm_pkg::CNT_LINE_VIOLATION] = 1'b1; // [R3] [R7]
      end else if (is_idx(s_axi_araddr, rpm_pkg::FRAME_ALIGN_ERROR_COUNT_HIGH_IDX)) begin
        rbyte = count[rpm_pkg::CNT_FRAME_ALIGN][15:8]; // [R4]
        rd_high[rpm_pkg::CNT_FRAME_ALIGN] = 1'b1; // [R3]
      end else if (is_idx(s_axi_araddr, rpm_pkg::FRAME_ALIGN_ERROR_COUNT_LOW_IDX)) begin
        rbyte = snap_valid[rpm_pkg::CNT_FRAME_ALIGN] ?
                snap_low[rpm_pkg::CNT_FRAME_ALIGN] :
                count[rpm_pkg::CNT_FRAME_ALIGN][7:0]; // [R5] [R6]
        rd_low[rpm_pkg::CNT_FRAME_ALIGN] = 1'b1; // [R3] [R7]
      end else if (is_idx(s_axi_araddr, rpm_pkg::IRQ_STATUS_IDX)) begin
        // status and mask reads have no side effect
        rbyte = {{(8 - NI){1'b0}}, irq_status};
      end else if (is_idx(s_axi_araddr, rpm_pkg::IRQ_MASK_IDX)) begin
        rbyte = {{(8 - NI){1'b0}}, irq_mask};
      end else begin
        next_rresp = rpm_pkg::RESP_SLVERR;
      end
      // upper lanes always read as zero; every register is one byte wide
      next_rdata = {24'h000000, rbyte};
    end else if (s_axi_rvalid && s_axi_rready) begin
      // answer taken: the channel frees up at this edge
      next_rvalid = 1'b0;
    end

    // one read in flight at most, so a second side effect never overtakes the first
    next_arready = !next_rvalid;
  end

  // register the read side
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= rpm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule

`default_nettype wire

// ===== tb/rpm_perf_monitor_assertions.sv
// concurrent checks on the ports of the receive performance monitor counter bank
`timescale 1ns/100ps
`default_nettype none

module rpm_perf_monitor_assertions #(
  parameter int ADDR_W = 14
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // bus and reset checks, all on the one clock
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not returned one cycle after address");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before it was taken");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read address accepted while data pending");
  byte_only_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data wider than one byte");
  counter_okay_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[13:4] == 10'h240 |=> s_axi_rresp == 2'h0)
    else $error("counter register read refused");
  error_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  write_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp) && !s_axi_awready)
    else $error("write response dropped before it was taken");
  reset_idle_a: assert property ($rose(resetn) |-> !s_axi_rvalid && !s_axi_bvalid && !irq)
    else $error("outputs not idle after reset");
endmodule

bind rpm_perf_monitor rpm_perf_monitor_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .mclk(mclk), .resetn(resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
);
`default_nettype wire

// ===== tb/rpm_perf_monitor_tb.sv
// self-checking bench for the receive performance monitor counter bank
`timescale 1ns/100ps
`default_nettype none

module rpm_perf_monitor_tb;
  logic mclk = 1'b0, resetn = 1'b0;
  logic line_violation_pulse = 1'b0, frame_align_error_pulse = 1'b0;
  logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, sts = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  logic irq_q[$];
  logic [15:0] lv = 16'h0, fa = 16'h0, h;
  int failures = 0, num_checks = 0, seed = 32'h4648;

  rpm_perf_monitor #(.ADDR_W(14)) DUT (
    .mclk(mclk), .resetn(resetn), .line_violation_pulse(line_violation_pulse),
    .frame_align_error_pulse(frame_align_error_pulse), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq)
  );

  always #2.5 mclk = ~mclk;

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // answer watcher: oldest note is compared whenever a response lands; irq notes are compared at every edge
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (resetn && s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata}, rd_q.size() ? rd_q.pop_front() : '1);
    if (resetn && s_axi_bvalid && s_axi_bready)
      check({32'h0, s_axi_bresp}, {32'h0, wr_q.size() ? wr_q.pop_front() : 2'h3});
    if (irq_q.size())
      check({33'h0, irq}, {33'h0, irq_q.pop_front()});
  end

  // bounded wait so a dead handshake shows up as a mismatch, not a hang
  task automatic wait_for(input int w);
    int n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((w == 0 ? s_axi_arready : w == 1 ? s_axi_rvalid : s_axi_bvalid) !== 1'b1
               && n < 200);
    if (n >= 200) check(34'(n), 34'h0);
  endtask

  // a random late ready lets the answer stand a cycle before it is taken
  task automatic rd(input logic [11:0] idx, input logic [7:0] val, input logic [1:0] resp);
    bit late;
    rd_q.push_back({resp, 24'h0, val});
    @(posedge mclk);
    late = 1'($random(seed));
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !late;
    wait_for(0);
    s_axi_arvalid <= 1'b0;
    wait_for(1);
    if (late) begin
      s_axi_rready <= 1'b1;
      @(posedge mclk);
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] data, input logic [1:0] resp);
    logic aw = 1'b0, w = 1'b0;
    int n = 0;
    bit late;
    wr_q.push_back(resp);
    @(posedge mclk);
    late = 1'($random(seed));
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !late;
    while (!(aw && w) && n < 200) begin
      @(posedge mclk);
      n++;
      if (s_axi_awready && !aw) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && !w) s_axi_wvalid <= 1'b0;
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
    end
    wait_for(2);
    if (late) begin
      s_axi_bready <= 1'b1;
      @(posedge mclk);
    end
    s_axi_bready <= 1'b0;
  endtask

  // events with random gaps; the model saturates and notes status bits
  task automatic pulses(input int n, input bit to_fa, input bit dense);
    bit p;
    while (n > 0) begin
      @(posedge mclk);
      p = dense | 1'($random(seed));
      line_violation_pulse <= p & !to_fa;
      frame_align_error_pulse <= p & to_fa;
      if (p) begin
        sts[to_fa] = 1'b1;
        if ((to_fa ? fa : lv) == 16'hFFFF) sts[2 + to_fa] = 1'b1;
        else if (to_fa) fa++;
        else lv++;
      end
      n -= p;
    end
    @(posedge mclk);
    line_violation_pulse <= 1'b0;
    frame_align_error_pulse <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(12'h900 + 12'(i), 8'h00, 2'h0);
    rd(12'h906, 8'h00, 2'h2);
    $display("reset values done");
    for (int c = 0; c < 2; c++) begin
      pulses(2 + ($random(seed) & 511), c[0], 1'b0);
      h = c ? fa : lv;
      rd(12'h900 + 12'(2 * c), h[15:8], 2'h0);
      rd(12'h901 + 12'(2 * c), h[7:0], 2'h0);
      rd(12'h901 + 12'(2 * c), 8'h00, 2'h0);
      if (c) fa = 16'h0;
      else lv = 16'h0;
    end
    pulses(300, 1'b0, 1'b0);
    h = lv;
    rd(12'h900, h[15:8], 2'h0);
    lv = 16'h0;
    pulses(5, 1'b0, 1'b0);
    rd(12'h901, h[7:0], 2'h0);
    rd(12'h901, lv[7:0], 2'h0);
    lv = 16'h0;
    $display("count and snapshot done");
    pulses(65540, 1'b0, 1'b1);
    rd(12'h900, 8'hFF, 2'h0);
    rd(12'h901, 8'hFF, 2'h0);
    rd(12'h904, {4'h0, sts}, 2'h0);
    irq_q.push_back(1'b0);
    wr(12'h905, 32'h1, 2'h0);
    @(posedge mclk);
    irq_q.push_back(1'b1);
    wr(12'h904, 32'hF, 2'h0);
    sts = 4'h0;
    @(posedge mclk);
    irq_q.push_back(1'b0);
    rd(12'h904, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hE;
    wr(12'h905, 32'hF, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(12'h905, 8'h01, 2'h0);
    wr(12'h900, 32'hFF, 2'h0);
    wr(12'h906, 32'h0, 2'h2);
    rd(12'h900, 8'h00, 2'h0);
    $display("saturation and interrupt done");
    end_sim;
  end

  initial begin
    #400000;
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
